// >>> rtl/sth_pkg.sv
// constants and carrier types for the self-test result and nvm register bank
// assumes a decoded serial frame arrives as one request per clock
package sth_pkg;

  // register addresses
  localparam logic [6:0] ADDR_CH7_LOW = 7'h56;
  localparam logic [6:0] ADDR_CH7_MID = 7'h57;
  localparam logic [6:0] ADDR_CH7_HIGH = 7'h58;
  localparam logic [6:0] ADDR_VOLT_LOW = 7'h59;
  localparam logic [6:0] ADDR_VOLT_MID = 7'h5A;
  localparam logic [6:0] ADDR_VOLT_HIGH = 7'h5B;
  localparam logic [6:0] ADDR_NVM_CMD = 7'h60;
  localparam logic [6:0] ADDR_NVM_D0 = 7'h61;
  localparam logic [6:0] ADDR_NVM_D1 = 7'h62;
  localparam logic [6:0] ADDR_NVM_D2 = 7'h63;

  // result registers, slot 0..5 = ch7 low/mid/high, voltage low/mid/high
  localparam int NUM_RESULTS = 6;
  localparam int RESULT_W = 10;
  localparam int RES_LSB = 4;
  localparam int FRESH_BIT = 1;
  localparam int PARITY_BIT = 0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

  // nvm command
  localparam int OPCODE_LSB = 8;
  localparam int OPCODE_W = 4;
  localparam logic [OPCODE_W-1:0] OP_READ = 4'hA;
  localparam logic [OPCODE_W-1:0] OP_WRITE = 4'hB;
  localparam logic [OPCODE_W-1:0] OP_SIMULATE = 4'hC;

  // nvm data word 0
  localparam int DITHER_LSB = 13;
  localparam int WDOG_LSB = 11;
  localparam int DSB_BIT = 10;
  localparam int WRCNT_LSB = 1;
  localparam int WRCNT_W = 9;
  localparam logic [WRCNT_W-1:0] WRCNT_MAX = 9'h1FF;

  // nvm data words 1 and 2
  localparam int THR_LSB = 2;
  localparam int THR_LOW_W = 14;
  localparam int THR7_LSB = 2;
  localparam int OUTST_LSB = 8;
  localparam int STBY_LSB = 4;

  typedef struct packed {
    logic [6:0] addr;
    logic rd;
    logic rc;
    logic wr;
    logic [15:0] wdata;
  } sth_reg_req_t;

  typedef struct packed {
    logic [RESULT_W-1:0] value;
    logic fresh;
  } sth_result_t;

  typedef struct packed {
    sth_result_t [NUM_RESULTS-1:0] res;
    logic [OPCODE_W-1:0] opcode;
    logic [2:0] dither;
    logic [1:0] wdog;
    logic dsb;
    logic [WRCNT_W-1:0] wr_count;
    logic [THR_LOW_W-1:0] thr;
    logic [1:0] thr7;
    logic [7:0] out_state;
    logic [3:0] stby_en;
    logic [15:0] rdata;
    logic [3:0] en;
  } sth_state_t;

endpackage : sth_pkg

// >>> rtl/sth_bank.sv
// self-test result registers and nvm programming window of an octal switch
// assumes the serial frame is decoded outside into one-cycle requests
// Functional notes
// - results in bits 13:4, reserved zero, reset zero
// - fresh flag bit 1 set on store, read clears
// - read-and-clear clears all clearable bits regardless payload
// - six results: ch7 and voltage, three levels
// - opcode bits 11:8, read/write/simulate codes
// - word0 holds dither, watchdog, deep-sleep block fields
// - word0 bits 9:1 read-only write tally, reset zero
// - word1 holds 2-bit thresholds for channels 0-6
// - channel 7 threshold in word2 bits 3:2
// - word2 bits 15:8 hold per-channel output state
// - word2 bits 7:4 standby enable states ch3-0
// - standby enables follow select: normal or nvm
`timescale 1ns/1ps
module sth_bank
  import sth_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire sth_reg_req_t REG_REQ_I,
  input wire logic [NUM_RESULTS-1:0] ADC_STORE_I,
  input wire logic [NUM_RESULTS-1:0][RESULT_W-1:0] ADC_VALUE_I,
  input wire logic NVM_WR_DONE_I,
  input wire logic STANDBY_I,
  input wire logic STBY_SRC_SEL_I,
  input wire logic [3:0] NORMAL_EN_I,
  output logic [15:0] REG_RDATA_O,
  output logic [OPCODE_W-1:0] NVM_OPCODE_O,
  output logic [2:0] DITHER_INC_O,
  output logic [1:0] WDOG_PERIOD_O,
  output logic DSB_BLOCK_O,
  output logic [15:0] CUR_THR_O,
  output logic [7:0] OUT_STATE_O,
  output logic [3:0] EN_O
);

  sth_state_t st;
  sth_state_t next_st;
  logic [15:0] rd_word;
  logic [6:0] slot;
  logic is_res;
  logic acc;

  // decode and next-state: reads, clears, writes, stores
  always_comb begin
    next_st = st;
    rd_word = 16'h0000;
    slot = REG_REQ_I.addr - ADDR_CH7_LOW;
    is_res = (REG_REQ_I.addr >= ADDR_CH7_LOW) && (REG_REQ_I.addr <= ADDR_VOLT_HIGH);
    acc = REG_REQ_I.rd || REG_REQ_I.rc;
    // read mux; unused bits stay zero
    if (is_res) begin
      rd_word[RES_LSB +: RESULT_W] = st.res[slot[2:0]].value;
      rd_word[FRESH_BIT] = st.res[slot[2:0]].fresh;
    end
    unique case (REG_REQ_I.addr)
      ADDR_NVM_CMD: rd_word[OPCODE_LSB +: OPCODE_W] = st.opcode;
      ADDR_NVM_D0: begin
        rd_word[DITHER_LSB +: 3] = st.dither;
        rd_word[WDOG_LSB +: 2] = st.wdog;
        rd_word[DSB_BIT] = st.dsb;
        rd_word[WRCNT_LSB +: WRCNT_W] = st.wr_count;
      end
      ADDR_NVM_D1: rd_word[THR_LSB +: THR_LOW_W] = st.thr;
      ADDR_NVM_D2: begin
        rd_word[OUTST_LSB +: 8] = st.out_state;
        rd_word[STBY_LSB +: 4] = st.stby_en;
        rd_word[THR7_LSB +: 2] = st.thr7;
      end
      default: ;
    endcase
    // odd parity over the whole word so an all-zero frame is caught
    rd_word[PARITY_BIT] = ~(^rd_word[15:1]);
    if (acc) begin
      next_st.rdata = rd_word;
    end
    // per-slot clear, then store so a same-cycle update is never lost
    for (int i = 0; i < NUM_RESULTS; i++) begin
      if (is_res && acc && (slot == 7'(i))) begin
        next_st.res[i].fresh = 1'b0;
        if (REG_REQ_I.rc) begin
          next_st.res[i].value = RESULT_RESET;
        end
      end
      if (ADC_STORE_I[i]) begin
        next_st.res[i].value = ADC_VALUE_I[i];
        next_st.res[i].fresh = 1'b1;
      end
    end
    // writes; read-only fields and results ignore the payload
    if (REG_REQ_I.wr) begin
      unique case (REG_REQ_I.addr)
        ADDR_NVM_CMD: next_st.opcode = REG_REQ_I.wdata[OPCODE_LSB +: OPCODE_W];
        ADDR_NVM_D0: begin
          next_st.dither = REG_REQ_I.wdata[DITHER_LSB +: 3];
          next_st.wdog = REG_REQ_I.wdata[WDOG_LSB +: 2];
          next_st.dsb = REG_REQ_I.wdata[DSB_BIT];
        end
        ADDR_NVM_D1: next_st.thr = REG_REQ_I.wdata[THR_LSB +: THR_LOW_W];
        ADDR_NVM_D2: begin
          next_st.out_state = REG_REQ_I.wdata[OUTST_LSB +: 8];
          next_st.stby_en = REG_REQ_I.wdata[STBY_LSB +: 4];
          next_st.thr7 = REG_REQ_I.wdata[THR7_LSB +: 2];
        end
        default: ;
      endcase
    end
    // write tally saturates rather than wrapping back to a fresh look
    if (NVM_WR_DONE_I && (st.wr_count != WRCNT_MAX)) begin
      next_st.wr_count = st.wr_count + 9'h001;
    end
    // enable source in standby
    if (STANDBY_I && STBY_SRC_SEL_I) begin
      next_st.en = st.stby_en;
    end else begin
      next_st.en = NORMAL_EN_I;
    end
  end

  // single state register, everything zero after reset
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign REG_RDATA_O = st.rdata;
  assign NVM_OPCODE_O = st.opcode;
  assign DITHER_INC_O = st.dither;
  assign WDOG_PERIOD_O = st.wdog;
  assign DSB_BLOCK_O = st.dsb;
  assign CUR_THR_O = {st.thr7, st.thr};
  assign OUT_STATE_O = st.out_state;
  assign EN_O = st.en;

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence s_res_read;
    acc && is_res && (ADC_STORE_I == '0);
  endsequence

  sequence s_res_clear;
    REG_REQ_I.rc && is_res && (ADC_STORE_I == '0);
  endsequence

  property p_reserved_zero;
    acc && is_res |=> (REG_RDATA_O[15:14] == 2'b00) && (REG_RDATA_O[3:2] == 2'b00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_store_sets;
    ADC_STORE_I[0] |=> st.res[0].fresh && (st.res[0].value == $past(ADC_VALUE_I[0]));
  endproperty
  a_store_sets: assert property (p_store_sets) else $error("store did not set flag");

  property p_read_clears;
    s_res_read |=> (st.res[$past(slot[2:0])].fresh == 1'b0);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read kept flag");

  property p_rc_clears;
    s_res_clear |=> (st.res[$past(slot[2:0])].value == RESULT_RESET);
  endproperty
  a_rc_clears: assert property (p_rc_clears) else $error("clear kept value");

  property p_opcode_wr;
    REG_REQ_I.wr && (REG_REQ_I.addr == ADDR_NVM_CMD) |=>
      (NVM_OPCODE_O == $past(REG_REQ_I.wdata[11:8]));
  endproperty
  a_opcode_wr: assert property (p_opcode_wr) else $error("opcode not stored");

  property p_cmd_read;
    acc && (REG_REQ_I.addr == ADDR_NVM_CMD) |=>
      (REG_RDATA_O[15:12] == 4'h0) && (REG_RDATA_O[7:1] == 7'h00);
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command spare bits set");

  property p_tally_inc;
    NVM_WR_DONE_I && (st.wr_count != WRCNT_MAX) |=> st.wr_count == $past(st.wr_count) + 9'h001;
  endproperty
  a_tally_inc: assert property (p_tally_inc) else $error("write tally not counted");

  property p_tally_read;
    acc && (REG_REQ_I.addr == ADDR_NVM_D0) |=> REG_RDATA_O[9:1] == $past(st.wr_count);
  endproperty
  a_tally_read: assert property (p_tally_read) else $error("tally readback wrong");

  property p_parity;
    acc |=> (^REG_RDATA_O) == 1'b1;
  endproperty
  a_parity: assert property (p_parity) else $error("parity wrong");

  property p_stby_src;
    STANDBY_I && STBY_SRC_SEL_I |=> EN_O == $past(st.stby_en);
  endproperty
  a_stby_src: assert property (p_stby_src) else $error("standby enable source wrong");

  property p_thr_wr;
    REG_REQ_I.wr && (REG_REQ_I.addr == ADDR_NVM_D2) |=>
      (CUR_THR_O[15:14] == $past(REG_REQ_I.wdata[3:2])) &&
      (OUT_STATE_O == $past(REG_REQ_I.wdata[15:8]));
  endproperty
  a_thr_wr: assert property (p_thr_wr) else $error("word2 write lost");

  // holes in the page answer with parity alone
  property p_unmapped_read;
    acc && !is_res && (REG_REQ_I.addr != ADDR_NVM_CMD) && (REG_REQ_I.addr != ADDR_NVM_D0) &&
      (REG_REQ_I.addr != ADDR_NVM_D1) && (REG_REQ_I.addr != ADDR_NVM_D2) |=>
      REG_RDATA_O == 16'h0001;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("hole read wrong");

  // read data stands until the next read, so a slow host still sees it
  property p_rdata_hold;
    !acc |=> REG_RDATA_O == $past(REG_RDATA_O);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // result field shows the stored value
  property p_res_value_read;
    acc && is_res |=> REG_RDATA_O[13:4] == $past(st.res[slot[2:0]].value);
  endproperty
  a_res_value_read: assert property (p_res_value_read) else $error("result wrong");

  // flag bit shows the state before the read drops it
  property p_res_flag_read;
    acc && is_res |=> REG_RDATA_O[1] == $past(st.res[slot[2:0]].fresh);
  endproperty
  a_res_flag_read: assert property (p_res_flag_read) else $error("flag readback wrong");

  // writes never reach a result slot
  property p_res_wr_ignored;
    REG_REQ_I.wr && is_res && (ADC_STORE_I == '0) |=> st.res == $past(st.res);
  endproperty
  a_res_wr_ignored: assert property (p_res_wr_ignored) else $error("result written");

  // read-and-clear drops the flag too
  property p_rc_flag;
    s_res_clear |=> st.res[$past(slot[2:0])].fresh == 1'b0;
  endproperty
  a_rc_flag: assert property (p_rc_flag) else $error("clear kept flag");

  // a plain read leaves the value alone
  property p_plain_keeps;
    REG_REQ_I.rd && is_res && (ADC_STORE_I == '0) |=>
      st.res[$past(slot[2:0])].value == $past(st.res[slot[2:0]].value);
  endproperty
  a_plain_keeps: assert property (p_plain_keeps) else $error("plain read lost value");

  // opcode moves only on a command write
  property p_opcode_hold;
    !(REG_REQ_I.wr && (REG_REQ_I.addr == ADDR_NVM_CMD)) |=>
      NVM_OPCODE_O == $past(NVM_OPCODE_O);
  endproperty
  a_opcode_hold: assert property (p_opcode_hold) else $error("opcode moved");

  // word0 write fields land one cycle later
  property p_d0_wr;
    REG_REQ_I.wr && (REG_REQ_I.addr == ADDR_NVM_D0) |=>
      (DITHER_INC_O == $past(REG_REQ_I.wdata[15:13])) &&
      (WDOG_PERIOD_O == $past(REG_REQ_I.wdata[12:11])) &&
      (DSB_BLOCK_O == $past(REG_REQ_I.wdata[10]));
  endproperty
  a_d0_wr: assert property (p_d0_wr) else $error("word0 write lost");

  // word0 readback of the writable fields
  property p_d0_read;
    acc && (REG_REQ_I.addr == ADDR_NVM_D0) |=>
      REG_RDATA_O[15:10] == $past({st.dither, st.wdog, st.dsb});
  endproperty
  a_d0_read: assert property (p_d0_read) else $error("word0 readback wrong");

  // tally is read-only: only a finished nvm write moves it
  property p_tally_idle;
    !NVM_WR_DONE_I |=> st.wr_count == $past(st.wr_count);
  endproperty
  a_tally_idle: assert property (p_tally_idle) else $error("tally moved");

  // tally sticks at its top instead of wrapping
  property p_tally_sat;
    NVM_WR_DONE_I && (st.wr_count == WRCNT_MAX) |=> st.wr_count == WRCNT_MAX;
  endproperty
  a_tally_sat: assert property (p_tally_sat) else $error("tally wrapped");

  // word1 thresholds for channels 0 to 6
  property p_d1_wr;
    REG_REQ_I.wr && (REG_REQ_I.addr == ADDR_NVM_D1) |=>
      CUR_THR_O[13:0] == $past(REG_REQ_I.wdata[15:2]);
  endproperty
  a_d1_wr: assert property (p_d1_wr) else $error("word1 write lost");

  // word1 readback with spare bit clear
  property p_d1_read;
    acc && (REG_REQ_I.addr == ADDR_NVM_D1) |=>
      (REG_RDATA_O[15:2] == $past(st.thr)) && !REG_RDATA_O[1];
  endproperty
  a_d1_read: assert property (p_d1_read) else $error("word1 readback wrong");

  // word2 readback with spare bit clear
  property p_d2_read;
    acc && (REG_REQ_I.addr == ADDR_NVM_D2) |=>
      (REG_RDATA_O[15:2] == $past({st.out_state, st.stby_en, st.thr7})) && !REG_RDATA_O[1];
  endproperty
  a_d2_read: assert property (p_d2_read) else $error("word2 readback wrong");

  // output states move only on a word2 write
  property p_out_hold;
    !(REG_REQ_I.wr && (REG_REQ_I.addr == ADDR_NVM_D2)) |=>
      OUT_STATE_O == $past(OUT_STATE_O);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output state moved");

  // standby enable bits from a word2 write
  property p_d2_stby;
    REG_REQ_I.wr && (REG_REQ_I.addr == ADDR_NVM_D2) |=>
      st.stby_en == $past(REG_REQ_I.wdata[7:4]);
  endproperty
  a_d2_stby: assert property (p_d2_stby) else $error("standby bits lost");

  // normal enables pass whenever the nvm source is not chosen
  property p_norm_src;
    !(STANDBY_I && STBY_SRC_SEL_I) |=> EN_O == $past(NORMAL_EN_I);
  endproperty
  a_norm_src: assert property (p_norm_src) else $error("normal enable source wrong");

  // per-slot set and keep of the fresh flag
  for (genvar g = 0; g < NUM_RESULTS; g++) begin : g_slot
    property p_store_slot;
      ADC_STORE_I[g] |=> st.res[g].fresh && (st.res[g].value == $past(ADC_VALUE_I[g]));
    endproperty
    a_store_slot: assert property (p_store_slot) else $error("slot store lost");
    property p_fresh_keep;
      !ADC_STORE_I[g] && !(acc && is_res && (slot == 7'(g))) |=>
        st.res[g].fresh == $past(st.res[g].fresh);
    endproperty
    a_fresh_keep: assert property (p_fresh_keep) else $error("fresh flag moved");
  end

endmodule : sth_bank

// >>> verification/sth_host.sv
// host side model: issues one-cycle register requests to the bank
// assumes the bank takes a request on the rising edge of clk_i
`timescale 1ns/1ps
module sth_host
  import sth_pkg::*;
(
  input wire logic clk_i,
  output sth_reg_req_t req_o
);
  initial req_o = '0;

  // one request per call; released fields show inverted junk, not stale data
  task automatic xfer(input logic [6:0] a, input logic [2:0] k, input logic [15:0] d);
    @(posedge clk_i);
    req_o <= '{a, k[2], k[1], k[0], d};
    @(posedge clk_i);
    req_o <= '{~a, 1'b0, 1'b0, 1'b0, ~d};
  endtask : xfer
endmodule : sth_host

// >>> verification/testbench.sv
// self-checking bench for the self-test result and nvm register bank
// assumes sth_host drives the register port; reference model kept in integers
`timescale 1ns/1ps
module testbench
  import sth_pkg::*;
;
  logic clk, rst, wr_done, stby, sel;
  sth_reg_req_t req;
  logic [5:0] store;
  logic [5:0][9:0] value;
  logic [3:0] norm_en, en, opc;
  logic [15:0] rdata, thr, d;
  logic [2:0] dith;
  logic [1:0] wdog;
  logic dsb;
  logic [7:0] outs;
  logic [3:0] ops [4] = '{OP_READ, OP_WRITE, OP_SIMULATE, 4'h5};
  int errors, check_count, seed, wrc;
  int res_v [6];
  int res_f [6];
  logic [15:0] m_cmd, m_d0, m_d1, m_d2;

  sth_host host (.clk_i(clk), .req_o(req));
  sth_bank dut (.REF_CLK_I(clk), .RESET_I(rst), .REG_REQ_I(req), .ADC_STORE_I(store),
    .ADC_VALUE_I(value), .NVM_WR_DONE_I(wr_done), .STANDBY_I(stby), .STBY_SRC_SEL_I(sel),
    .NORMAL_EN_I(norm_en), .REG_RDATA_O(rdata), .NVM_OPCODE_O(opc), .DITHER_INC_O(dith),
    .WDOG_PERIOD_O(wdog), .DSB_BLOCK_O(dsb), .CUR_THR_O(thr), .OUT_STATE_O(outs), .EN_O(en));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // expected read word, odd parity in bit 0
  function automatic logic [15:0] expv(input logic [6:0] a);
    logic [15:0] v;
    int i;
    i = int'(a) - int'(ADDR_CH7_LOW);
    v = 16'h0000;
    if (i >= 0 && i < NUM_RESULTS) v = 16'(res_v[i] * 16 + res_f[i] * 2);
    if (a == ADDR_NVM_CMD) v = m_cmd & 16'h0F00;
    if (a == ADDR_NVM_D0) v = {m_d0[15:10], 9'(wrc), 1'b0};
    if (a == ADDR_NVM_D1) v = m_d1 & 16'hFFFC;
    if (a == ADDR_NVM_D2) v = m_d2 & 16'hFFFC;
    v[0] = ~^v[15:1];
    return v;
  endfunction : expv

  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    check_count++;
    if (got !== e) begin
      errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, e);
    end
  endtask : chk

  // any read drops the fresh flag; only read-and-clear zeroes the value
  task automatic rd(input logic [6:0] a, input logic [2:0] k);
    logic [15:0] e;
    int i;
    e = expv(a);
    i = int'(a) - int'(ADDR_CH7_LOW);
    host.xfer(a, k, 16'($random(seed)));
    #1 chk(rdata, e);
    if (i >= 0 && i < NUM_RESULTS) begin
      res_f[i] = 0;
      if (k[1]) res_v[i] = 0;
    end
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [15:0] dw);
    host.xfer(a, 3'b001, dw);
    case (a)
      ADDR_NVM_CMD: m_cmd = dw;
      ADDR_NVM_D0: m_d0 = dw;
      ADDR_NVM_D1: m_d1 = dw;
      ADDR_NVM_D2: m_d2 = dw;
      default: ;
    endcase
    #1;
  endtask : wr

  task automatic chkf();
    chk({6'h00, opc, dith, wdog, dsb}, {6'h00, m_cmd[11:8], m_d0[15:10]});
    chk(thr, {m_d2[3:2], m_d1[15:2]});
    chk({8'h00, outs}, {8'h00, m_d2[15:8]});
  endtask : chkf

  task automatic store1(input int i, input int v);
    @(posedge clk);
    store <= 6'(1 << i);
    value[i] <= 10'(v);
    @(posedge clk);
    store <= 6'h00;
    res_v[i] = v & 1023;
    res_f[i] = 1;
  endtask : store1

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // watchdog well beyond the roughly 180 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    seed = 32'h9D110FDB;
    rst = 1'b1;
    {wr_done, stby, sel, store, value, norm_en} = '0;
    {m_cmd, m_d0, m_d1, m_d2, wrc} = '0;
    foreach (res_v[i]) {res_v[i], res_f[i]} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values of the whole page, gaps read parity only
    for (int a = 32'h56; a <= 32'h64; a++) rd(7'(a), 3'b100);
    $display("test reset values done");
    for (int i = 0; i < NUM_RESULTS; i++) begin
      store1(i, $random(seed));
      wr(7'(int'(ADDR_CH7_LOW) + i), 16'($random(seed)));
      rd(7'(int'(ADDR_CH7_LOW) + i), 3'b100);
      rd(7'(int'(ADDR_CH7_LOW) + i), 3'b100);
      store1(i, $random(seed));
      rd(7'(int'(ADDR_CH7_LOW) + i), 3'b010);
      rd(7'(int'(ADDR_CH7_LOW) + i), 3'b100);
    end
    $display("test result registers done");
    foreach (ops[j]) begin
      d = 16'($random(seed));
      d[11:8] = ops[j];
      wr(ADDR_NVM_CMD, d);
      rd(ADDR_NVM_CMD, 3'b100);
      chkf();
    end
    for (int a = 32'h61; a <= 32'h63; a++) begin
      wr(7'(a), 16'($random(seed)));
      rd(7'(a), 3'b100);
      chkf();
    end
    repeat (3) begin
      @(posedge clk) wr_done <= 1'b1;
      @(posedge clk) wr_done <= 1'b0;
      wrc++;
    end
    rd(ADDR_NVM_D0, 3'b100);
    $display("test nvm words done");
    for (int j = 0; j < 8; j++) begin
      @(posedge clk);
      stby <= j[0];
      sel <= j[1];
      norm_en <= 4'($random(seed));
      repeat (2) @(posedge clk);
      #1 chk({12'h000, en}, {12'h000, (stby && sel) ? m_d2[7:4] : norm_en});
    end
    $display("test standby enables done");
    print_verdict();
  end
endmodule : testbench
